// ### inc/rsef_map.svh
// Register offsets, field positions, reset values and sizes of the reader sync and filter block.
`ifndef RSEF_MAP_SVH
`define RSEF_MAP_SVH

// Register offsets on the plain register port.
`define RSEF_OFF_TX_CTRL 8'h36
`define RSEF_OFF_SYNC_CFG 8'h39
`define RSEF_OFF_FILTER 8'h43
`define RSEF_OFF_STATUS 8'h44

// Reset values.
`define RSEF_TX_CTRL_RST 32'h00000000
`define RSEF_SYNC_CFG_RST 32'h00000000
`define RSEF_FILTER_RST 32'h00000000

// Transmit control fields.
`define RSEF_TX_INVERT_BIT 0
`define RSEF_TX_COND_SW_BIT 1

// Sync configuration fields.
`define RSEF_SYNC_VAL_MSB 31
`define RSEF_SYNC_VAL_LSB 16
`define RSEF_SYNC_PATTERN_LENGTH_MSB 15
`define RSEF_SYNC_PATTERN_LENGTH_LSB 12
`define RSEF_SYNC_NEG_BIT 11
`define RSEF_SYNC_HALF_BIT 10
`define RSEF_SYNC_TYPE_MSB 9
`define RSEF_SYNC_TYPE_LSB 8
`define RSEF_SYNC_VAL_LOAD 16'hB24D
`define RSEF_SYNC_PATTERN_LENGTH_LOAD 4'hF

// Response filter fields.
`define RSEF_FLT_RC_MSB 31
`define RSEF_FLT_RC_LSB 24
`define RSEF_FLT_MAX_MSB 23
`define RSEF_FLT_MAX_LSB 16
`define RSEF_FLT_MIN_MSB 15
`define RSEF_FLT_MIN_LSB 8
`define RSEF_FLT_INTEG_BIT 4
`define RSEF_FLT_PROT_BIT 3
`define RSEF_FLT_RC_EN_BIT 2
`define RSEF_FLT_LEN_EN_BIT 1
`define RSEF_FLT_MASTER_BIT 0

// Frame layout and receive buffer size.
`define RSEF_RC_BYTE_IDX 2'h0
`define RSEF_LEN_BYTE_IDX 2'h1
`define RSEF_BUF_DEPTH 256
`define RSEF_BUF_AW 8

`endif

// ### inc/rsef_pkg.sv
// Types shared by the reader sync and filter block.
package rsef_pkg;

  // Receive sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_HUNT = 4'h1,
    ST_DATA = 4'h2,
    ST_JUDGE = 4'h4,
    ST_DRAIN = 4'h8
  } rsef_state_t;

  // Interpretation of the sync value field.
  typedef enum logic [1:0] {
    SYNC_PLAIN = 2'h0,
    SYNC_CODED = 2'h1,
    SYNC_BYTE = 2'h2,
    SYNC_RSVD = 2'h3
  } rsef_sync_type_t;

endpackage : rsef_pkg

// ### inc/rsef_rx_if.sv
// Byte stream and verdict between the receive sequencer and the disturbance checker.
`timescale 1ns/10ps
`default_nettype none

interface rsef_rx_if;
  logic sof;
  logic byte_vld;
  logic [7:0] byte_val;
  logic frame_end;
  logic crc_err;
  logic prot_err;
  logic verdict_vld;
  logic verdict_emd;

  modport src (output sof, byte_vld, byte_val, frame_end, crc_err, prot_err, input verdict_vld, verdict_emd);
  modport chk (input sof, byte_vld, byte_val, frame_end, crc_err, prot_err, output verdict_vld, verdict_emd);
endinterface : rsef_rx_if

`default_nettype wire

// ### src/rsef_emd_check.sv
// Classifies one received response as disturbance or as a valid frame.
`timescale 1ns/10ps
`default_nettype none
`include "rsef_map.svh"

module rsef_emd_check (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronised reset, active low.
  input wire logic [31:0] cfg, // Response filter register.
  rsef_rx_if.chk rx // Byte stream in, verdict out.
);

  logic [1:0] nb_q;
  logic [1:0] nb_d;
  logic [7:0] rc_q;
  logic [7:0] rc_d;
  logic [7:0] len_q;
  logic [7:0] len_d;
  logic vld_q;
  logic emd_q;

  // Byte count and captured bytes, including a byte that lands with the frame end.
  assign nb_d = (rx.byte_vld & (nb_q != 2'h3)) ? nb_q + 2'h1 : nb_q;
  assign rc_d = (rx.byte_vld & (nb_q == `RSEF_RC_BYTE_IDX)) ? rx.byte_val : rc_q;
  assign len_d = (rx.byte_vld & (nb_q == `RSEF_LEN_BYTE_IDX)) ? rx.byte_val : len_q;

  wire master = cfg[`RSEF_FLT_MASTER_BIT];
  wire rc_fail = cfg[`RSEF_FLT_RC_EN_BIT] & ((nb_d == 2'h0) | (rc_d != cfg[`RSEF_FLT_RC_MSB:`RSEF_FLT_RC_LSB]));
  wire len_hi = len_d > cfg[`RSEF_FLT_MAX_MSB:`RSEF_FLT_MAX_LSB];
  wire len_lo = len_d < cfg[`RSEF_FLT_MIN_MSB:`RSEF_FLT_MIN_LSB];
  wire len_fail = cfg[`RSEF_FLT_LEN_EN_BIT] & ((nb_d < 2'h2) | len_hi | len_lo);
  wire int_fail = cfg[`RSEF_FLT_INTEG_BIT] & rx.crc_err;
  wire prot_fail = cfg[`RSEF_FLT_PROT_BIT] & rx.prot_err;
  wire emd_d = master & (rc_fail | len_fail | int_fail | prot_fail);

  // Capture state; a new frame start clears the previous capture.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nb_q <= 2'h0;
      rc_q <= 8'h00;
      len_q <= 8'h00;
    end else if (rx.sof) begin
      nb_q <= 2'h0;
      rc_q <= 8'h00;
      len_q <= 8'h00;
    end else begin
      nb_q <= nb_d;
      rc_q <= rc_d;
      len_q <= len_d;
    end
  end

  // Verdict follows the frame end by one cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= 1'b0;
      emd_q <= 1'b0;
    end else begin
      vld_q <= rx.frame_end;
      emd_q <= rx.frame_end & emd_d;
    end
  end

  assign rx.verdict_vld = vld_q;
  assign rx.verdict_emd = emd_q;

endmodule : rsef_emd_check

`default_nettype wire

// ### src/rsef_top.sv
// Reader-mode transmit shaping, receive sync hunter and response disturbance filter.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "rsef_map.svh"

// Notes on behaviour
// - Invert bit set outputs the inverted transmit modulation, else unchanged.
// - Switch bit set drives card-mode conductance from transmission-in-progress, not envelope.
// - Transmit-active follows transmission-in-progress, registered one cycle later.
// - Receiver hunts the preamble held in the sync value field first.
// - Number of valid sync bits equals the length field plus one.
// - Negative-edge mode starts the frame at a falling edge, no correlation.
// - Half-last mode requires the final sync bit at half length.
// - Type zero uses plain bits; type one uses data and collision pairs.
// - Type two resynchronises on the start bit of every byte.
// - Loading the 212/424 configuration sets sync value B24D and length F.
// - Code check flags a frame whose first byte differs from expected.
// - Length check flags a length byte above the maximum.
// - Length check flags a length byte below the minimum.
// - Integrity check flags a response with an integrity error.
// - Protocol check flags a response with a protocol error.
// - Code check disabled accepts any code; needs master enable.
// - Length check disabled accepts any length; needs master enable.
// - Master enable clear ignores every filter setting.
// - Response filter register resets to all zeros.

module rsef_top (
  input wire logic clk_sys, // System clock, 50 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire logic tx_envelope, // Transmit modulation envelope.
  input wire logic tx_in_progress, // Encoder is sending a frame.
  output logic tx_mod, // Shaped modulation signal.
  output logic tx_active, // Transmission-active indication.
  output logic cm_conductance, // Card-mode conductance value switch.
  input wire logic load_rf_configuration, // Configuration load pulse.
  input wire logic load_proto_212_424, // Load selects the 212/424 reader protocol.
  input wire logic rx_bit_vld, // One demodulated bit this cycle.
  input wire logic rx_bit, // Demodulated bit value.
  input wire logic rx_bit_coll, // Collision seen on this bit.
  input wire logic rx_bit_half, // This bit lasted half a bit period.
  input wire logic rx_fall_edge, // Falling edge of the received envelope.
  input wire logic rx_frame_end, // End of the received frame.
  input wire logic rx_crc_err, // Integrity error, valid with frame end.
  input wire logic rx_prot_err, // Protocol error, valid with frame end.
  output logic [7:0] rx_data, // Accepted frame byte.
  output logic rx_data_vld, // Byte valid.
  output logic rx_data_last, // Last byte of the frame.
  output logic sync_found // Start of frame detected.
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and register access.

  // Address compare used by every register select.
  function automatic logic rsef_hit(input logic [7:0] addr, input logic [7:0] off);
    rsef_hit = (addr == off);
  endfunction : rsef_hit

  logic rst_meta_q;
  logic rst_n_q;

  // Reset is applied at once and released after two edges.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [31:0] txc_q;
  logic [31:0] syn_q;
  logic [31:0] flt_q;
  logic [31:0] syn_d;
  logic [31:0] rdata_q;
  logic [7:0] drop_cnt_q;
  rsef_pkg::rsef_state_t st_q;
  rsef_pkg::rsef_state_t st_d;

  // Register selects.
  wire sel_txc = rsef_hit(reg_addr, `RSEF_OFF_TX_CTRL);
  wire sel_syn = rsef_hit(reg_addr, `RSEF_OFF_SYNC_CFG);
  wire sel_flt = rsef_hit(reg_addr, `RSEF_OFF_FILTER);
  wire sel_sts = rsef_hit(reg_addr, `RSEF_OFF_STATUS);
  wire load_hit = load_rf_configuration & load_proto_212_424;

  assign syn_d = load_hit ? {`RSEF_SYNC_VAL_LOAD, `RSEF_SYNC_PATTERN_LENGTH_LOAD, syn_q[11:0]} :
                 (reg_wr & sel_syn) ? reg_wdata : syn_q;

  // Read multiplexer; unmapped addresses read zero.
  wire [31:0] sts_word = {16'h0000, drop_cnt_q, 4'h0, st_q};
  wire [31:0] rd_mux = sel_txc ? txc_q : sel_syn ? syn_q : sel_flt ? flt_q : sel_sts ? sts_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      txc_q <= `RSEF_TX_CTRL_RST;
      syn_q <= `RSEF_SYNC_CFG_RST;
      flt_q <= `RSEF_FILTER_RST;
      rdata_q <= 32'h00000000;
    end else begin
      txc_q <= (reg_wr & sel_txc) ? reg_wdata : txc_q;
      syn_q <= syn_d;
      flt_q <= (reg_wr & sel_flt) ? reg_wdata : flt_q;
      rdata_q <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shaping.

  logic tx_mod_q;
  logic tx_act_q;
  logic cond_q;

  wire tx_mod_d = tx_envelope ^ txc_q[`RSEF_TX_INVERT_BIT];
  wire cond_d = txc_q[`RSEF_TX_COND_SW_BIT] ? tx_in_progress : tx_envelope;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_mod_q <= 1'b0;
      tx_act_q <= 1'b0;
      cond_q <= 1'b0;
    end else begin
      tx_mod_q <= tx_mod_d;
      tx_act_q <= tx_in_progress;
      cond_q <= cond_d;
    end
  end

  assign tx_mod = tx_mod_q;
  assign tx_active = tx_act_q;
  assign cm_conductance = cond_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync hunter.

  wire [15:0] sync_val = syn_q[`RSEF_SYNC_VAL_MSB:`RSEF_SYNC_VAL_LSB];
  wire [3:0] sync_pattern_length = syn_q[`RSEF_SYNC_PATTERN_LENGTH_MSB:`RSEF_SYNC_PATTERN_LENGTH_LSB];
  wire sync_neg = syn_q[`RSEF_SYNC_NEG_BIT];
  wire sync_half = syn_q[`RSEF_SYNC_HALF_BIT];
  wire [1:0] sync_type = syn_q[`RSEF_SYNC_TYPE_MSB:`RSEF_SYNC_TYPE_LSB];
  wire mode_coded = (sync_type == rsef_pkg::SYNC_CODED);
  wire mode_byte = (sync_type == rsef_pkg::SYNC_BYTE);
  wire in_hunt = (st_q == rsef_pkg::ST_HUNT);
  wire in_data = (st_q == rsef_pkg::ST_DATA);

  logic [15:0] hbit_q;
  logic [15:0] hcoll_q;
  logic [4:0] hcnt_q;

  // History including the bit arriving now; index 0 is the newest bit.
  wire [15:0] hbit_d = {hbit_q[14:0], rx_bit};
  wire [15:0] hcoll_d = {hcoll_q[14:0], rx_bit_coll};
  wire [15:0] plain_ok;
  wire [15:0] coded_ok;

  // Per-position pattern compare, last pattern bit in sync value bit 0.
  for (genvar i = 0; i < 16; i++) begin : g_cmp
    wire unused_pos = 4'(i) > sync_pattern_length;
    assign plain_ok[i] = unused_pos | (hbit_d[i] == sync_val[i]);
    if (i < 8) begin : g_coded
      wire [1:0] grp = sync_val[2 * i + 1:2 * i];
      assign coded_ok[i] = unused_pos | (grp[0] ? hcoll_d[i] : (!hcoll_d[i] & (hbit_d[i] == grp[1])));
    end else begin : g_none
      assign coded_ok[i] = 1'b1;
    end
  end

  wire enough = hcnt_q >= {1'b0, sync_pattern_length};
  wire half_ok = !sync_half | rx_bit_half;
  wire pat_hit = rx_bit_vld & enough & half_ok & (mode_coded ? &coded_ok : &plain_ok);
  wire sof_hit = in_hunt & (sync_neg ? rx_fall_edge : mode_byte ? (rx_bit_vld & !rx_bit) : pat_hit);

  // Bit history advances only while hunting.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hbit_q <= 16'h0000;
      hcoll_q <= 16'h0000;
      hcnt_q <= 5'h00;
    end else if (!in_hunt | sof_hit) begin
      hcnt_q <= 5'h00;
    end else if (rx_bit_vld) begin
      hbit_q <= hbit_d;
      hcoll_q <= hcoll_d;
      hcnt_q <= (hcnt_q == 5'h10) ? hcnt_q : hcnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly and frame buffer.

  logic [7:0] sh_q;
  logic [2:0] bcnt_q;
  logic wait_start_q;
  logic [`RSEF_BUF_AW:0] wcnt_q;
  logic [`RSEF_BUF_AW:0] rptr_q;
  logic [7:0] buf_mem [0:`RSEF_BUF_DEPTH-1];

  wire take_bit = in_data & rx_bit_vld & !(mode_byte & wait_start_q);
  wire start_seen = in_data & rx_bit_vld & mode_byte & wait_start_q & !rx_bit;
  wire [7:0] asm_byte = mode_byte ? {rx_bit, sh_q[7:1]} : {sh_q[6:0], rx_bit};
  wire byte_done = take_bit & (bcnt_q == 3'h7);
  wire buf_room = wcnt_q < (`RSEF_BUF_AW + 1)'(`RSEF_BUF_DEPTH);
  wire frm_end = in_data & rx_frame_end;

  // Shift register and bit counter; byte mode takes bits LSB first.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      wait_start_q <= 1'b0;
    end else if (sof_hit | start_seen) begin
      bcnt_q <= 3'h0;
      wait_start_q <= 1'b0;
    end else if (take_bit) begin
      sh_q <= asm_byte;
      bcnt_q <= bcnt_q + 3'h1;
      wait_start_q <= mode_byte & byte_done;
    end
  end

  // Buffer fill level; restarts with every frame.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wcnt_q <= '0;
    end else if (sof_hit) begin
      wcnt_q <= '0;
    end else if (byte_done & buf_room) begin
      wcnt_q <= wcnt_q + 1'b1;
    end
  end

  // Frame bytes are held until the verdict is known.
  always_ff @(posedge clk_sys) begin
    if (byte_done & buf_room) begin
      buf_mem[wcnt_q[`RSEF_BUF_AW-1:0]] <= asm_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Disturbance checker and receive sequencer.

  rsef_rx_if rx_if ();

  assign rx_if.sof = sof_hit;
  assign rx_if.byte_vld = byte_done;
  assign rx_if.byte_val = asm_byte;
  assign rx_if.frame_end = frm_end;
  assign rx_if.crc_err = rx_crc_err;
  assign rx_if.prot_err = rx_prot_err;

  rsef_emd_check u_check (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .cfg(flt_q),
    .rx(rx_if.chk)
  );

  wire keep = rx_if.verdict_vld & !rx_if.verdict_emd & (wcnt_q != '0);
  wire drain_last = (st_q == rsef_pkg::ST_DRAIN) & (rptr_q == wcnt_q - 1'b1);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      rsef_pkg::ST_HUNT: begin
        if (sof_hit) begin
          st_d = rsef_pkg::ST_DATA;
        end
      end
      rsef_pkg::ST_DATA: begin
        if (frm_end) begin
          st_d = rsef_pkg::ST_JUDGE;
        end
      end
      rsef_pkg::ST_JUDGE: begin
        if (rx_if.verdict_vld) begin
          st_d = keep ? rsef_pkg::ST_DRAIN : rsef_pkg::ST_HUNT;
        end
      end
      rsef_pkg::ST_DRAIN: begin
        if (drain_last) begin
          st_d = rsef_pkg::ST_HUNT;
        end
      end
      default: begin
        st_d = rsef_pkg::ST_HUNT;
      end
    endcase
  end

  logic [7:0] rxd_q;
  logic rxv_q;
  logic rxl_q;
  logic sync_q;

  // State, drain pointer and discarded-frame counter.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= rsef_pkg::ST_HUNT;
      rptr_q <= '0;
      drop_cnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      rptr_q <= (st_q == rsef_pkg::ST_DRAIN) ? rptr_q + 1'b1 : '0;
      drop_cnt_q <= drop_cnt_q + {7'h00, rx_if.verdict_vld & rx_if.verdict_emd};
    end
  end

  // Accepted bytes leave one per cycle during the drain.
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rxd_q <= 8'h00;
      rxv_q <= 1'b0;
      rxl_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      rxd_q <= (st_q == rsef_pkg::ST_DRAIN) ? buf_mem[rptr_q[`RSEF_BUF_AW-1:0]] : 8'h00;
      rxv_q <= (st_q == rsef_pkg::ST_DRAIN);
      rxl_q <= drain_last;
      sync_q <= sof_hit;
    end
  end

  assign rx_data = rxd_q;
  assign rx_data_vld = rxv_q;
  assign rx_data_last = rxl_q;
  assign sync_found = sync_q;

endmodule : rsef_top

`default_nettype wire

// ### tb/rsef_card.sv
// Behavioural card that sends sync bits, bytes and frame ends to the receiver.
`timescale 1ns/10ps
`default_nettype none

module rsef_card (
  input wire logic clk_sys, // System clock.
  output logic bit_vld, // Bit strobe.
  output logic bit_val, // Bit value.
  output logic bit_coll, // Collision on the bit.
  output logic bit_half, // Half-length bit.
  output logic fall, // Falling edge.
  output logic fend, // End of frame.
  output logic crc_err, // Integrity error.
  output logic prot_err // Protocol error.
);
  int gap = 0; // Idle cycles after each bit; raised to answer slowly.

  // Everything idle at time zero.
  initial begin
    {bit_vld, bit_val, bit_coll, bit_half, fall, fend, crc_err, prot_err} <= 8'h00;
  end

  // One bit; qualifiers invert once the strobe drops.
  task automatic send_bit(input logic b, input logic c, input logic h);
    bit_vld <= 1'b1;
    {bit_val, bit_coll, bit_half} <= {b, c, h};
    @(posedge clk_sys);
    if (gap > 0) begin
      bit_vld <= 1'b0;
      {bit_val, bit_coll, bit_half} <= ~{b, c, h};
      repeat (gap) @(posedge clk_sys);
    end
  endtask : send_bit

  // Release the bit strobe for one cycle.
  task automatic rest();
    bit_vld <= 1'b0;
    @(posedge clk_sys);
  endtask : rest

  // Falling edge of the envelope.
  task automatic edge_fall();
    fall <= 1'b1;
    @(posedge clk_sys);
    fall <= 1'b0;
  endtask : edge_fall

  // Byte, most significant bit first.
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i], 1'b0, 1'b0);
  endtask : send_byte

  // Frame end with its error flags.
  task automatic end_frame(input logic ce, input logic pe);
    bit_vld <= 1'b0;
    {fend, crc_err, prot_err} <= {1'b1, ce, pe};
    @(posedge clk_sys);
    {fend, crc_err, prot_err} <= {1'b0, ~ce, ~pe};
  endtask : end_frame
endmodule : rsef_card

`default_nettype wire

// ### tb/rsef_top_assertions.sv
// Port-level checks of the reader sync and filter block.
`timescale 1ns/10ps
`default_nettype none
`include "rsef_map.svh"

module rsef_top_assertions (
  input wire logic clk_sys, // System clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic tx_envelope, // Envelope in.
  input wire logic tx_in_progress, // Sending.
  input wire logic tx_mod, // Shaped envelope.
  input wire logic tx_active, // Active indication.
  input wire logic cm_conductance, // Conductance switch.
  input wire logic rx_bit_vld, // Bit strobe.
  input wire logic rx_fall_edge, // Falling edge.
  input wire logic rx_frame_end, // Frame end.
  input wire logic rx_crc_err, // Integrity error.
  input wire logic rx_prot_err, // Protocol error.
  input wire logic rx_data_vld, // Byte strobe.
  input wire logic rx_data_last, // Last byte.
  input wire logic sync_found // Start of frame.
);
  logic [1:0] age_q; // Edges since reset release, saturating.
  logic [31:0] tx_q; // Shadow of the transmit control word.
  logic [31:0] flt_q; // Shadow of the filter word.
  logic in_data_q; // A frame is being received.
  wire rdy = age_q == 2'h3;
  wire wr_tx = reg_wr && reg_addr == `RSEF_OFF_TX_CTRL;
  wire wr_flt = reg_wr && reg_addr == `RSEF_OFF_FILTER;

  // Shadows of host writes; the age count skips the reset sync.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      age_q <= 2'h0;
      tx_q <= 32'h0;
      flt_q <= 32'h0;
      in_data_q <= 1'b0;
    end else begin
      if (!rdy) age_q <= age_q + 2'h1;
      if (wr_tx) tx_q <= reg_wdata;
      if (wr_flt) flt_q <= reg_wdata;
      if (sync_found) in_data_q <= 1'b1;
      else if (rx_frame_end) in_data_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit shaping, filter read, start of frame, delivery timing, last byte and dropped frames.
  property p_tx_mod;
    rdy |-> tx_mod == ($past(tx_envelope) ^ $past(tx_q[0]));
  endproperty
  a_tx_mod: assert property (p_tx_mod) else $error("shaped envelope wrong");
  property p_cm;
    rdy |-> cm_conductance == $past(tx_q[1] ? tx_in_progress : tx_envelope);
  endproperty
  a_cm: assert property (p_cm) else $error("conductance source wrong");
  property p_act;
    rdy |-> tx_active == $past(tx_in_progress);
  endproperty
  a_act: assert property (p_act) else $error("active indication wrong");
  property p_flt_rd;
    rdy && reg_rd && reg_addr == `RSEF_OFF_FILTER |=> reg_rdata == $past(flt_q);
  endproperty
  a_flt_rd: assert property (p_flt_rd) else $error("filter word read wrong");
  property p_sync;
    sync_found |-> $past(rx_bit_vld || rx_fall_edge);
  endproperty
  a_sync: assert property (p_sync) else $error("start of frame without a bit");
  property p_lat;
    $rose(rx_data_vld) |-> $past(rx_frame_end, 3);
  endproperty
  a_lat: assert property (p_lat) else $error("first byte at wrong time");
  sequence s_last_out;
    rx_data_vld ##1 !rx_data_vld;
  endsequence
  property p_last;
    rx_data_last |-> s_last_out;
  endproperty
  a_last: assert property (p_last) else $error("last byte marking wrong");
  sequence s_bad_end;
    in_data_q && rx_frame_end && flt_q[0] && ((flt_q[4] && rx_crc_err) || (flt_q[3] && rx_prot_err));
  endsequence
  property p_drop;
    s_bad_end |=> !rx_data_vld [*8];
  endproperty
  a_drop: assert property (p_drop) else $error("error frame was delivered");
endmodule : rsef_top_assertions

bind rsef_top rsef_top_assertions u_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tx_envelope, .tx_in_progress, .tx_mod, .tx_active, .cm_conductance, .rx_bit_vld, .rx_fall_edge,
  .rx_frame_end, .rx_crc_err, .rx_prot_err, .rx_data_vld, .rx_data_last, .sync_found);

`default_nettype wire

// ### tb/rsef_top_tb.sv
// Self-checking bench of the reader sync and filter block.
`timescale 1ns/10ps
`default_nettype none
`include "rsef_map.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end

module rsef_top_tb;
  logic clk_sys, nrst, reg_wr, reg_rd, tx_envelope, tx_in_progress, load_rf_configuration, load_proto_212_424;
  logic [7:0] reg_addr, rx_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic tx_mod, tx_active, cm_conductance, rx_bit_vld, rx_bit, rx_bit_coll, rx_bit_half, rx_fall_edge;
  logic rx_frame_end, rx_crc_err, rx_prot_err, rx_data_vld, rx_data_last, sync_found;
  int bad_count = 0;
  int checks = 0;
  int sync_n = 0;
  logic [7:0] got_q[$];
  // Sync cases: configuration, refused stimulus, accepted stimulus as {fall, half, coll, bit}.
  logic [31:0] scfg [5] = '{32'h00010000, 32'h00010100, 32'h00010400, 32'h00000800, 32'h00000200};
  logic [3:0] sneg [5] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h1};
  logic [3:0] spos [5] = '{4'h1, 4'h2, 4'h5, 4'h8, 4'h0};
  // Filter cases: filter word and frame {ok, prot, crc, length, code}.
  logic [31:0] fw [12] = '{32'hA5101C1E, 32'hA5000001, 32'hA5000005, 32'hA5000005, 32'h00100803, 32'h00100803,
    32'h00100803, 32'h00100803, 32'h00100801, 32'h00FF0019, 32'h00FF0019, 32'h00000009};
  logic [18:0] ff [12] = '{19'h7203C, 19'h4203C, 19'h420A5, 19'h0203C, 19'h0113C, 19'h0073C,
    19'h4103C, 19'h4083C, 19'h4203C, 19'h2203C, 19'h1203C, 19'h5203C};

  rsef_top uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_envelope,
    .tx_in_progress, .tx_mod, .tx_active, .cm_conductance, .load_rf_configuration, .load_proto_212_424,
    .rx_bit_vld, .rx_bit, .rx_bit_coll, .rx_bit_half, .rx_fall_edge, .rx_frame_end, .rx_crc_err, .rx_prot_err,
    .rx_data, .rx_data_vld, .rx_data_last, .sync_found);

  rsef_card card (.clk_sys(clk_sys), .bit_vld(rx_bit_vld), .bit_val(rx_bit), .bit_coll(rx_bit_coll),
    .bit_half(rx_bit_half), .fall(rx_fall_edge), .fend(rx_frame_end), .crc_err(rx_crc_err),
    .prot_err(rx_prot_err));

  // Clock of 20 ns.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Collects delivered bytes and counts starts of frame.
  always @(posedge clk_sys) begin
    if (rx_data_vld === 1'b1) got_q.push_back(rx_data);
    if (sync_found === 1'b1) sync_n++;
  end

  // Verdict and end of run.
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Register write, one strobe cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Register read; data checked in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd

  // Configuration load pulse.
  task automatic load(input logic p);
    @(posedge clk_sys);
    {load_rf_configuration, load_proto_212_424} <= {1'b1, p};
    @(posedge clk_sys);
    load_rf_configuration <= 1'b0;
  endtask : load

  // One sync stimulus in the {fall, half, coll, bit} form.
  task automatic poke(input logic [3:0] s);
    if (s[3]) card.edge_fall();
    else card.send_bit(s[0], s[1], s[2]);
    card.rest();
    repeat (3) @(posedge clk_sys);
  endtask : poke

  // Watchdog.
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {nrst, reg_wr, reg_rd, tx_envelope, tx_in_progress, load_rf_configuration, load_proto_212_424} <= 7'h00;
    {reg_addr, reg_wdata} <= 40'h0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`RSEF_OFF_TX_CTRL, `RSEF_TX_CTRL_RST);
    rd(`RSEF_OFF_FILTER, `RSEF_FILTER_RST);
    wr(`RSEF_OFF_TX_CTRL, 32'hFFFFFFFF);
    wr(8'h60, 32'hFFFFFFFF);
    wr(`RSEF_OFF_STATUS, 32'hFFFFFFFF);
    rd(`RSEF_OFF_TX_CTRL, 32'hFFFFFFFF);
    rd(8'h60, 32'h00000000);
    rd(`RSEF_OFF_STATUS, 32'h00000001);
    $display("Registers test done");
    for (int k = 0; k < 16; k++) begin
      if (k % 4 == 0) wr(`RSEF_OFF_TX_CTRL, 32'(k >> 2));
      @(posedge clk_sys);
      {tx_envelope, tx_in_progress} <= {k[0], k[1]};
      @(posedge clk_sys);
      #1 `CHK(tx_mod, k[0] ^ k[2])
      `CHK(cm_conductance, k[3] ? k[1] : k[0])
      `CHK(tx_active, k[1])
    end
    $display("Transmit test done");
    wr(`RSEF_OFF_SYNC_CFG, 32'h12340A00);
    load(1'b0);
    rd(`RSEF_OFF_SYNC_CFG, 32'h12340A00);
    load(1'b1);
    rd(`RSEF_OFF_SYNC_CFG, 32'hB24DFA00);
    wr(`RSEF_OFF_SYNC_CFG, 32'h1234FA00);
    rd(`RSEF_OFF_SYNC_CFG, 32'h1234FA00);
    $display("Load test done");
    for (int i = 0; i < 5; i++) begin
      wr(`RSEF_OFF_SYNC_CFG, scfg[i]);
      sync_n = 0;
      poke(sneg[i]);
      `CHK(sync_n, 0)
      poke(spos[i]);
      `CHK(sync_n, 1)
      card.end_frame(1'b0, 1'b0);
      repeat (6) @(posedge clk_sys);
    end
    $display("Sync test done");
    wr(`RSEF_OFF_SYNC_CFG, 32'hB24DF000);
    for (int i = 0; i < 12; i++) begin
      wr(`RSEF_OFF_FILTER, fw[i]);
      card.gap = i % 2 * 2;
      got_q.delete();
      for (int b = 15; b >= 0; b--) card.send_bit(`RSEF_SYNC_VAL_LOAD >> b, 1'b0, 1'b0);
      card.send_byte(ff[i][7:0]);
      card.send_byte(ff[i][15:8]);
      card.send_byte(8'h5A);
      card.end_frame(ff[i][16], ff[i][17]);
      repeat (10) @(posedge clk_sys);
      `CHK(got_q.size(), ff[i][18] ? 3 : 0)
      if (ff[i][18] && got_q.size() == 3) begin
        `CHK({got_q[0], got_q[1], got_q[2]}, {ff[i][7:0], ff[i][15:8], 8'h5A})
      end
    end
    $display("Filter test done");
    stop_test();
  end
endmodule : rsef_top_tb

`default_nettype wire
